//--- hdl/pbps_pkg.sv
package pbps_pkg;
   localparam int PortW   = 8;
   localparam int P3W     = 5;
   localparam int AddrW   = 24;
   localparam int DataW   = 16;
   // Port three bit positions
   localparam int P3Rd    = 0;
   localparam int P3WrLo  = 1;
   localparam int P3WrHi  = 2;
   localparam int P3Wait  = 3;
   localparam int P3Req   = 4;
   // Field positions on the internal buses
   localparam int AdLoLsb  = 0;
   localparam int AdHiLsb  = 8;
   localparam int AdTopLsb = 16;
   // Reset values
   localparam logic [PortW-1:0] PortRst  = 8'h00;
   localparam logic [PortW-1:0] OeOffAll = 8'hFF;
   localparam logic [P3W-1:0]   P3Rst    = 5'h00;
   localparam logic [P3W-1:0]   P3OeOff  = 5'h1F;
   localparam logic [DataW-1:0] DataRst  = 16'h0000;
   // Bus ownership, Gray coded
   typedef enum logic [0:0] {
      OWN_BUS  = 1'h0,
      FREE_BUS = 1'h1
   } pbps_own_t;
endpackage : pbps_pkg

//--- hdl/pbps_arb_if.sv
interface pbps_arb_if;
   logic waitRaw;
   logic reqRaw;
   logic waitEn;
   logic reqEn;
   logic busIdle;
   logic holdBus;
   logic granted;
   modport ctl (input waitRaw, reqRaw, waitEn, reqEn, busIdle, output holdBus, granted);
   modport mux (output waitRaw, reqRaw, waitEn, reqEn, busIdle, input holdBus, granted);
endinterface : pbps_arb_if

//--- hdl/pbps_arb.sv
module pbps_arb (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Arbitration carrier
   pbps_arb_if.ctl  arb
);
   logic [2:0]        waitSync_q;
   logic [2:0]        reqSync_q;
   logic              waitLvl_q;
   logic              reqLvl_q;
   pbps_pkg::pbps_own_t own_q;

   // -------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         waitSync_q <= 3'h0;
         reqSync_q  <= 3'h0;
      end else begin
         waitSync_q <= {waitSync_q[1:0], ~arb.waitRaw};
         reqSync_q  <= {reqSync_q[1:0], ~arb.reqRaw};
      end
   end

   // A change counts only once stages two and three agree, filtering one-cycle glitches
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         waitLvl_q <= 1'h0;
         reqLvl_q  <= 1'h0;
      end else begin
         if (waitSync_q[1] == waitSync_q[2]) begin
            waitLvl_q <= waitSync_q[2];
         end
         if (reqSync_q[1] == reqSync_q[2]) begin
            reqLvl_q <= reqSync_q[2];
         end
      end
   end

   // -------------------------------------------------
   // Ownership
   // -------------------------------------------------
   // Release only between cycles so a running access is never cut in half
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         own_q <= pbps_pkg::OWN_BUS;
      end else begin
         unique case (own_q)
            pbps_pkg::OWN_BUS: begin
               if (arb.reqEn && reqLvl_q && arb.busIdle) begin
                  own_q <= pbps_pkg::FREE_BUS;
               end
            end
            pbps_pkg::FREE_BUS: begin
               if (!(arb.reqEn && reqLvl_q)) begin
                  own_q <= pbps_pkg::OWN_BUS;
               end
            end
         endcase
      end
   end

   assign arb.holdBus = arb.waitEn & waitLvl_q;
   assign arb.granted = (own_q == pbps_pkg::FREE_BUS);
endmodule : pbps_arb

//--- hdl/pbps_pin_mux.sv
module pbps_pin_mux (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Function selects
   input  wire logic        port0BusSel,
   input  wire logic        port1BusSel,
   input  wire logic        port1AddrOnly,
   input  wire logic        port2BusSel,
   input  wire logic        port2TopByte,
   input  wire logic [4:0]  port3FuncSel,
   // General-purpose port settings, direction 1 = output
   input  wire logic [7:0]  gpioDir0,
   input  wire logic [7:0]  gpioDir1,
   input  wire logic [7:0]  gpioDir2,
   input  wire logic [7:0]  gpioOut0,
   input  wire logic [7:0]  gpioOut1,
   input  wire logic [7:0]  gpioOut2,
   input  wire logic [4:0]  port3Dir,
   input  wire logic [4:0]  port3Out,
   output logic      [7:0]  gpioIn0,
   output logic      [7:0]  gpioIn1,
   output logic      [7:0]  gpioIn2,
   output logic      [4:0]  port3In,
   // Bus controller side
   input  wire logic [23:0] busAddr,
   input  wire logic [15:0] busWrData,
   input  wire logic        busAddrPhase,
   input  wire logic        busRead,
   input  wire logic        busWrite,
   input  wire logic        busWrLow,
   input  wire logic        busWrHigh,
   input  wire logic        busIdle,
   output logic      [15:0] busRdData,
   output logic             busHold,
   output logic             bus_grant_out,
   output logic             readWrite,
   // Pins, output enables active low
   input  wire logic [7:0]  port_zero_pins_in,
   output logic      [7:0]  port_zero_pins_out,
   output logic      [7:0]  port_zero_pins_oe_n,
   input  wire logic [7:0]  port_one_pins_in,
   output logic      [7:0]  port_one_pins_out,
   output logic      [7:0]  port_one_pins_oe_n,
   input  wire logic [7:0]  port_two_pins_in,
   output logic      [7:0]  port_two_pins_out,
   output logic      [7:0]  port_two_pins_oe_n,
   input  wire logic [4:0]  port_three_pins_in,
   output logic      [4:0]  port_three_pins_out,
   output logic      [4:0]  port_three_pins_oe_n,
   output logic      [4:0]  port_three_pull_up_en
);
   pbps_arb_if arb ();

   logic [7:0]  p0Out_d, p1Out_d, p2Out_d, p0Oe_d, p1Oe_d, p2Oe_d;
   logic [4:0]  p3Out_d, p3Oe_d;
   logic [7:0]  in0S1_q, in0S2_q, in0S3_q;
   logic [7:0]  in1S1_q, in1S2_q, in1S3_q;
   logic [7:0]  in2S1_q, in2S2_q, in2S3_q;
   logic [4:0]  in3S1_q, in3S2_q, in3S3_q;
   logic        own;
   logic        drvData;

   assign arb.waitRaw = port_three_pins_in[pbps_pkg::P3Wait];
   assign arb.reqRaw  = port_three_pins_in[pbps_pkg::P3Req];
   assign arb.waitEn  = port3FuncSel[pbps_pkg::P3Wait];
   assign arb.reqEn   = port3FuncSel[pbps_pkg::P3Req];
   assign arb.busIdle = busIdle;

   pbps_arb pbps_arb_i (
      .core_clk (core_clk),
      .rst      (rst),
      .arb      (arb)
   );

   assign own     = ~arb.granted;
   // Data pins drive only in the data phase of a write
   assign drvData = own & busWrite & ~busAddrPhase;

   // -------------------------------------------------
   // Pin value and enable selection
   // -------------------------------------------------
   always_comb begin
      // Ports zero to two as general-purpose pins
      p0Out_d = gpioOut0;
      p1Out_d = gpioOut1;
      p2Out_d = gpioOut2;
      p0Oe_d  = ~gpioDir0;
      p1Oe_d  = ~gpioDir1;
      p2Oe_d  = ~gpioDir2;
      if (port0BusSel) begin
         p0Out_d = busAddrPhase ? busAddr[pbps_pkg::AdLoLsb +: pbps_pkg::PortW]
                                : busWrData[pbps_pkg::AdLoLsb +: pbps_pkg::PortW];
         p0Oe_d  = (own && (busAddrPhase || drvData)) ? pbps_pkg::PortRst : pbps_pkg::OeOffAll;
      end
      if (port1BusSel) begin
         if (port1AddrOnly) begin
            p1Out_d = busAddr[pbps_pkg::AdHiLsb +: pbps_pkg::PortW];
            p1Oe_d  = own ? pbps_pkg::PortRst : pbps_pkg::OeOffAll;
         end else begin
            p1Out_d = busAddrPhase ? busAddr[pbps_pkg::AdHiLsb +: pbps_pkg::PortW]
                                   : busWrData[pbps_pkg::AdHiLsb +: pbps_pkg::PortW];
            p1Oe_d  = (own && (busAddrPhase || drvData)) ? pbps_pkg::PortRst : pbps_pkg::OeOffAll;
         end
      end
      if (port2BusSel) begin
         p2Out_d = port2TopByte ? busAddr[pbps_pkg::AdTopLsb +: pbps_pkg::PortW]
                                : busAddr[pbps_pkg::AdLoLsb +: pbps_pkg::PortW];
         p2Oe_d  = own ? pbps_pkg::PortRst : pbps_pkg::OeOffAll;
      end
      // Port three: bits 30 and 31 turn round only as strobes, floating while the bus is granted
      p3Out_d = port3Out;
      p3Oe_d  = ~port3Dir;
      p3Oe_d[pbps_pkg::P3Rd]   = 1'h0;
      p3Oe_d[pbps_pkg::P3WrLo] = 1'h0;
      if (port3FuncSel[pbps_pkg::P3Rd]) begin
         p3Out_d[pbps_pkg::P3Rd] = ~(own & busRead);
         p3Oe_d[pbps_pkg::P3Rd]  = ~own;
      end
      if (port3FuncSel[pbps_pkg::P3WrLo]) begin
         p3Out_d[pbps_pkg::P3WrLo] = ~(own & busWrLow);
         p3Oe_d[pbps_pkg::P3WrLo]  = ~own;
      end
      if (port3FuncSel[pbps_pkg::P3WrHi]) begin
         p3Out_d[pbps_pkg::P3WrHi] = ~(own & busWrHigh);
         p3Oe_d[pbps_pkg::P3WrHi]  = ~own;
      end
      // Wait and request are inputs whenever selected
      if (port3FuncSel[pbps_pkg::P3Wait]) begin
         p3Oe_d[pbps_pkg::P3Wait] = 1'h1;
      end
      if (port3FuncSel[pbps_pkg::P3Req]) begin
         p3Oe_d[pbps_pkg::P3Req] = 1'h1;
      end
   end

   // -------------------------------------------------
   // Registered pin drivers
   // -------------------------------------------------
   // Reset leaves every pin floating so nothing fights the board before setup
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         port_zero_pins_out    <= pbps_pkg::PortRst;
         port_one_pins_out     <= pbps_pkg::PortRst;
         port_two_pins_out     <= pbps_pkg::PortRst;
         port_zero_pins_oe_n   <= pbps_pkg::OeOffAll;
         port_one_pins_oe_n    <= pbps_pkg::OeOffAll;
         port_two_pins_oe_n    <= pbps_pkg::OeOffAll;
         port_three_pins_out   <= pbps_pkg::P3OeOff;
         port_three_pins_oe_n  <= pbps_pkg::P3OeOff;
         port_three_pull_up_en <= pbps_pkg::P3Rst;
      end else begin
         port_zero_pins_out    <= p0Out_d;
         port_one_pins_out     <= p1Out_d;
         port_two_pins_out     <= p2Out_d;
         port_zero_pins_oe_n   <= p0Oe_d;
         port_one_pins_oe_n    <= p1Oe_d;
         port_two_pins_oe_n    <= p2Oe_d;
         port_three_pins_out   <= p3Out_d;
         port_three_pins_oe_n  <= p3Oe_d;
         // Pull-ups only on bits 32-34 and only while not driving
         port_three_pull_up_en <= {p3Oe_d[pbps_pkg::P3Req:pbps_pkg::P3WrHi], 2'h0};
      end
   end

   // -------------------------------------------------
   // Input capture
   // -------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         {in0S1_q, in0S2_q, in0S3_q} <= {3{pbps_pkg::PortRst}};
         {in1S1_q, in1S2_q, in1S3_q} <= {3{pbps_pkg::PortRst}};
         {in2S1_q, in2S2_q, in2S3_q} <= {3{pbps_pkg::PortRst}};
         {in3S1_q, in3S2_q, in3S3_q} <= {3{pbps_pkg::P3Rst}};
      end else begin
         in0S1_q <= port_zero_pins_in;
         in0S2_q <= in0S1_q;
         in0S3_q <= in0S2_q;
         in1S1_q <= port_one_pins_in;
         in1S2_q <= in1S1_q;
         in1S3_q <= in1S2_q;
         in2S1_q <= port_two_pins_in;
         in2S2_q <= in2S1_q;
         in2S3_q <= in2S2_q;
         in3S1_q <= port_three_pins_in;
         in3S2_q <= in3S1_q;
         in3S3_q <= in3S2_q;
      end
   end

   // A bit moves only once stages two and three agree, so a pin caught mid-swing never shows up
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         gpioIn0   <= pbps_pkg::PortRst;
         gpioIn1   <= pbps_pkg::PortRst;
         gpioIn2   <= pbps_pkg::PortRst;
         port3In   <= pbps_pkg::P3Rst;
         busRdData <= pbps_pkg::DataRst;
      end else begin
         gpioIn0   <= (in0S2_q & in0S3_q) | (gpioIn0 & (in0S2_q ^ in0S3_q));
         gpioIn1   <= (in1S2_q & in1S3_q) | (gpioIn1 & (in1S2_q ^ in1S3_q));
         gpioIn2   <= (in2S2_q & in2S3_q) | (gpioIn2 & (in2S2_q ^ in2S3_q));
         port3In   <= (in3S2_q & in3S3_q) | (port3In & (in3S2_q ^ in3S3_q));
         busRdData <= ({in1S2_q, in0S2_q} & {in1S3_q, in0S3_q})
                    | (busRdData & ({in1S2_q, in0S2_q} ^ {in1S3_q, in0S3_q}));
      end
   end

   // -------------------------------------------------
   // Bus status
   // -------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         busHold       <= 1'h0;
         bus_grant_out <= 1'h0;
         readWrite     <= 1'h1;
      end else begin
         busHold       <= arb.holdBus;
         bus_grant_out <= arb.granted;
         readWrite     <= ~busWrite;
      end
   end
endmodule : pbps_pin_mux

//--- sim/pbps_pin_mux_sva.sv
module pbps_pin_mux_sva (
   // Selects
   input wire logic        core_clk, rst, port0BusSel, port1BusSel, port1AddrOnly, port2BusSel, port2TopByte,
   input wire logic [4:0]  port3FuncSel, port3Dir,
   input wire logic [7:0]  gpioDir0, gpioOut0,
   // Bus controller side
   input wire logic [23:0] busAddr,
   input wire logic        busAddrPhase, busRead, busWrite, busWrLow, busWrHigh, busHold, bus_grant_out, readWrite,
   // Pins
   input wire logic [7:0]  port_zero_pins_out, port_zero_pins_oe_n, port_one_pins_out, port_two_pins_out,
   input wire logic [4:0]  port_three_pins_in, port_three_pins_out, port_three_pins_oe_n, port_three_pull_up_en
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_gpio_drive: assert property (!port0BusSel |=> port_zero_pins_oe_n == ~$past(gpioDir0)
      && port_zero_pins_out == $past(gpioOut0)) else $error("gpio drive wrong");
   a_addr_low: assert property (port0BusSel && busAddrPhase && !bus_grant_out ##1 !bus_grant_out
      |-> !port_zero_pins_oe_n && port_zero_pins_out == $past(busAddr[7:0])) else $error("addr low wrong");
   a_addr_mid: assert property (port1BusSel && port1AddrOnly && !bus_grant_out |=>
      port_one_pins_out == $past(busAddr[15:8])) else $error("addr mid wrong");
   a_addr_two: assert property (port2BusSel && !bus_grant_out |=> port_two_pins_out ==
      ($past(port2TopByte) ? $past(busAddr[23:16]) : $past(busAddr[7:0]))) else $error("port two addr wrong");
   a_rd_strobe: assert property (port3FuncSel[0] && busRead && !busAddrPhase && !bus_grant_out |=>
      !port_three_pins_out[0]) else $error("read strobe missing");
   a_out_only: assert property (!$past(rst) && $past(port3FuncSel[1:0]) == 2'b00 |->
      port_three_pins_oe_n[1:0] == 2'b00) else $error("output-only bit floats");
   a_wr_strobes: assert property (port3FuncSel[2:1] == 2'b11 && busWrite && !busAddrPhase && !bus_grant_out
      |=> port_three_pins_out[2:1] == ~$past({busWrHigh, busWrLow})) else $error("write strobes wrong");
   a_rw_dir: assert property (!$past(rst) |-> readWrite == !$past(busWrite)) else $error("direction wrong");
   a_wait_hold: assert property ((port3FuncSel[3] && !port_three_pins_in[3]) [*7] |-> busHold)
      else $error("wait ignored");
   a_req_drop: assert property ((port_three_pins_in[4]) [*8] |-> !bus_grant_out) else $error("grant stuck");
   a_grant_float: assert property (bus_grant_out && $past(bus_grant_out) && port0BusSel && $past(port0BusSel)
      |-> port_zero_pins_oe_n == 8'hFF) else $error("bus pins driven while granted");
   a_pull_up: assert property (!$past(rst) |-> port_three_pull_up_en == {port_three_pins_oe_n[4:2], 2'b00})
      else $error("pull-up wrong");
   a_p3_dir: assert property (!$past(rst) && $past(port3FuncSel[4:2]) == 3'b000 |->
      port_three_pins_oe_n[4:2] == ~$past(port3Dir[4:2])) else $error("port three direction wrong");
endmodule : pbps_pin_mux_sva

//--- sim/pbps_ext_model.sv
module pbps_ext_model #(parameter logic [15:0] RdWord = 16'hC3A5) (
   // Test controls
   input wire logic       waitOn, reqOn,
   // Device pins
   input wire logic [7:0] port_zero_pins_out, port_zero_pins_oe_n, port_one_pins_out, port_one_pins_oe_n,
   input wire logic [7:0] port_two_pins_out, port_two_pins_oe_n,
   input wire logic [4:0] port_three_pins_out, port_three_pins_oe_n,
   output logic     [7:0] port_zero_pins_in, port_one_pins_in, port_two_pins_in,
   output logic     [4:0] port_three_pins_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       rdOn;
   logic [7:0] fl0, fl1;
   // Memory answers only while the read strobe pin is driven low
   assign rdOn = !port_three_pins_oe_n[0] && !port_three_pins_out[0];
   // Released lines show the inverse, so stale data never looks right
   assign fl0 = rdOn ? RdWord[7:0] : ~port_zero_pins_out;
   assign fl1 = rdOn ? RdWord[15:8] : ~port_one_pins_out;
   assign port_zero_pins_in = port_zero_pins_oe_n & fl0 | ~port_zero_pins_oe_n & port_zero_pins_out;
   assign port_one_pins_in = port_one_pins_oe_n & fl1 | ~port_one_pins_oe_n & port_one_pins_out;
   assign port_two_pins_in = port_two_pins_oe_n & ~port_two_pins_out | ~port_two_pins_oe_n & port_two_pins_out;
   // Bits two to four have pull-ups; wait and request are active low
   assign port_three_pins_in = port_three_pins_oe_n & {~reqOn, ~waitOn, 1'b1, ~port_three_pins_out[1:0]}
      | ~port_three_pins_oe_n & port_three_pins_out;
endmodule : pbps_ext_model

//--- sim/pbps_pin_mux_test.sv
module pbps_pin_mux_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 0, rst = 1, port0BusSel, port1BusSel, port1AddrOnly, port2BusSel, port2TopByte;
   logic        busAddrPhase, busRead, busWrite, busWrLow, busWrHigh, busIdle, busHold, bus_grant_out, readWrite;
   logic        waitOn, reqOn;
   logic [4:0]  port3FuncSel, port3Dir, port3Out, port3In, port_three_pins_in, port_three_pins_out;
   logic [4:0]  port_three_pins_oe_n, port_three_pull_up_en;
   logic [7:0]  gpioDir0, gpioDir1, gpioDir2, gpioOut0, gpioOut1, gpioOut2, gpioIn0, gpioIn1, gpioIn2;
   logic [7:0]  port_zero_pins_in, port_zero_pins_out, port_zero_pins_oe_n, port_one_pins_in, port_one_pins_out;
   logic [7:0]  port_one_pins_oe_n, port_two_pins_in, port_two_pins_out, port_two_pins_oe_n;
   logic [15:0] busWrData, busRdData;
   logic [23:0] busAddr;
   int          err_total = 0, check_count = 0;
   always #5 core_clk = ~core_clk;
   pbps_pin_mux pbps_pin_mux_i (.*);
   pbps_ext_model pbps_ext_model_i (.*);
   // ----------------
   // Scenarios
   // ----------------
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic t_gpio;
      {gpioDir0, gpioOut0, gpioDir1, gpioOut1, gpioDir2, gpioOut2} = {8'hA5, 8'h3C, 8'h0F, 8'h5F, 8'hFF, 8'h81};
      {port3Dir, port3Out} = {5'h04, 5'h1B};
      cyc(1);
      chk(port_zero_pins_oe_n, 8'h5A);
      chk(port_one_pins_oe_n, 8'hF0);
      chk(port_two_pins_out, 8'h81);
      chk(port_three_pull_up_en, 5'h18);
      cyc(5);
      chk({gpioIn0, gpioIn1, gpioIn2}, 24'h66_AF81);
      chk(port3In, 5'h1B);
   endtask : t_gpio
   task automatic t_write;
      {gpioDir0, gpioDir1, gpioDir2, port0BusSel, port1BusSel, port2BusSel} = {24'h00_0000, 3'b111};
      {port3FuncSel, busAddr, busAddrPhase} = {5'h07, 24'h12_3456, 1'b1};
      cyc(1);
      chk({port_zero_pins_out, port_one_pins_out, port_two_pins_out}, 24'h56_3456);
      chk({port_zero_pins_oe_n, port_two_pins_oe_n}, 16'h0000);
      {busAddrPhase, busWrite, busWrLow, busWrHigh, busWrData} = {4'b0111, 16'hBEEF};
      cyc(1);
      chk({port_zero_pins_out, port_one_pins_out, port_zero_pins_oe_n}, 24'hEF_BE00);
      chk({port_three_pins_out[2:0], readWrite}, 4'h2);
      busWrHigh = 1'b0;
      cyc(1);
      chk(port_three_pins_out[2:1], 2'b10);
      {busWrite, busWrLow} = 2'b00;
   endtask : t_write
   task automatic t_read;
      busRead = 1'b1;
      cyc(1);
      chk({port_zero_pins_oe_n, port_three_pins_out[0], readWrite}, 10'h3FD);
      cyc(6);
      chk(busRdData, 16'hC3A5);
      {port1AddrOnly, port2TopByte} = 2'b11;
      cyc(1);
      chk({port_one_pins_out, port_one_pins_oe_n, port_two_pins_out}, 24'h34_0012);
      busRead = 1'b0;
   endtask : t_read
   task automatic t_wait;
      port3FuncSel = 5'h0F;
      waitOn = 1'b1;
      cyc(7);
      chk(busHold, 1'b1);
      waitOn = 1'b0;
      cyc(6);
      chk(busHold, 1'b0);
      waitOn = 1'b1;
      cyc(1);
      waitOn = 1'b0;
      for (int i = 0; i < 6; i++) begin
         cyc(1);
         chk(busHold, 1'b0);
      end
   endtask : t_wait
   task automatic t_req;
      {port3FuncSel, reqOn, busIdle} = {5'h17, 2'b10};
      cyc(8);
      chk(bus_grant_out, 1'b0);
      busIdle = 1'b1;
      cyc(8);
      chk({bus_grant_out, port_zero_pins_oe_n, port_two_pins_oe_n, port_three_pins_oe_n[2:0]}, 20'hF_FFFF);
      reqOn = 1'b0;
      cyc(8);
      chk({bus_grant_out, port_two_pins_oe_n}, 9'h000);
   endtask : t_req
   task automatic test_done;
      $display("Checks %0d, errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   initial begin
      {port0BusSel, port1BusSel, port1AddrOnly, port2BusSel, port2TopByte, busAddrPhase, busRead, busWrite} = '0;
      {busWrLow, busWrHigh, waitOn, reqOn, port3FuncSel, port3Dir, gpioDir0, gpioDir1, gpioDir2} = '0;
      {gpioOut0, gpioOut1, gpioOut2, busWrData, busAddr} = '0;
      {port3Out, busIdle} = {5'h1F, 1'b1};
      cyc(4);
      rst = 1'b0;
      cyc(1);
      t_gpio;
      t_write;
      t_read;
      t_wait;
      t_req;
      test_done;
   end
   initial begin
      #20000;
      err_total++;
      test_done;
   end
endmodule : pbps_pin_mux_test
bind pbps_pin_mux pbps_pin_mux_sva pbps_pin_mux_sva_i (.*);
